// >>> design/dbsr_pkg.sv
// shared constants, field layout and carrier types of the status register bank
package dbsr_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TX_EN_TIME_NS = 4000;
  localparam int TX_EN_CYC = (TX_EN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARM_W = $clog2(TX_EN_CYC + 1);
  // ---------------------------------------------------------------
  // frame layout and register map
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam int DATA_LSB = 8;
  localparam int CMD_CLEAR_BIT = 7;
  localparam logic [6:0] ADDR_DEV_INFO = 7'h43;
  localparam logic [6:0] ADDR_BUS_A = 7'h44;
  localparam logic [6:0] ADDR_BUS_B = 7'h45;
  localparam logic [7:0] REG_RST = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DI_PRIOR_LSB = 6;
  localparam int DI_STUCK = 5;
  localparam int DI_MONERR = 4;
  localparam int DI_WDCNT_LSB = 2;
  localparam int DI_INVCMD = 1;
  localparam int DI_FOACT = 0;
  localparam int BA_LIN1_LSB = 5;
  localparam int BA_CAN_LSB = 1;
  localparam int BA_CANUV = 0;
  localparam int BB_LIN4_LSB = 5;
  localparam int BB_LIN3_LSB = 3;
  localparam int BB_LIN2_LSB = 1;
  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [1:0] PRIOR_CLEARED = 2'h0;
  localparam logic [1:0] PRIOR_FAIL = 2'h1;
  localparam logic [1:0] PRIOR_SLEEP = 2'h2;
  localparam logic [1:0] WD_NONE = 2'h0;
  localparam logic [1:0] WD_ONE = 2'h1;
  localparam logic [1:0] WD_TWO = 2'h2;
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_TSD = 2'h1;
  localparam logic [1:0] FLT_TXD = 2'h2;
  localparam logic [1:0] FLT_BUS = 2'h3;
  // channel 0 is the CAN transceiver, 1..4 the LIN channels
  localparam int NCH = 5;
  localparam int CH_CAN = 0;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {CAN_OFF, CAN_WAKE, CAN_RX_ONLY, CAN_NORMAL} dbsr_can_mode_t;
  typedef enum logic [1:0] {TX_ON, TX_HOLD, TX_ARM} dbsr_tx_state_t;
  typedef struct packed {
    logic tsd_evt;
    logic txd_to_evt;
    logic bus_to_evt;
    logic hot;
    logic bus_dom;
    logic supply_low;
    logic quiet;
  } dbsr_trx_in_t;
  typedef struct packed {
    logic restart;
    logic watchdog_miss_count;
    logic thermal_stage_two;
    logic core_supply_low;
    logic core_supply_high;
    logic core_overvoltage_reset_enable;
    logic wake_failsafe;
    logic wake_sleep;
  } dbsr_restart_t;
endpackage

// >>> design/dbsr_status_regs.sv
// status register bank with its 16-bit serial command port and transmitter gating
module dbsr_status_regs
  import dbsr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic soft_reset,
  // serial port, own clock
  input wire logic spi_sclk,
  input wire logic spi_cs_b,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // restart and supervision events
  input wire dbsr_restart_t restart_info,
  input wire logic watchdog_miss,
  input wire logic watchdog_ok,
  input wire logic fail_cfg_one,
  input wire logic fail_output_release,
  input wire logic monitor_input_error,
  input wire logic reset_drive_low,
  input wire logic reset_pin_level,
  output logic fail_output_pins,
  // transceivers
  input wire dbsr_trx_in_t trx_in [NCH],
  input wire logic txd_pin [NCH],
  input wire dbsr_can_mode_t can_mode,
  input wire logic can_wup_seen,
  output logic [NCH-1:0] tx_enable
);
  // ---------------------------------------------------------------
  // serial side
  // ---------------------------------------------------------------
  logic in_frame_q;
  logic sdo_q;
  logic sdo_oe_q;
  logic [CNT_W-1:0] bit_cnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [7:0] resp_q;
  logic [CNT_W-1:0] cnt_nx;

  assign cnt_nx = in_frame_q ? bit_cnt_q + CNT_W'(1) : CNT_W'(1);

  // chip select idle clears frame tracking and the data driver at once
  always_ff @(posedge spi_sclk or posedge spi_cs_b or negedge rst_b) begin
    if (!rst_b || spi_cs_b) begin
      in_frame_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      in_frame_q <= 1'b1;
      sdo_oe_q <= 1'b1;
      // resp_q stays still during frames, so reading it here is safe
      // rise k launches frame bit k-1, so data bits 8..15 follow rises 9..16
      if (cnt_nx > CNT_W'(DATA_LSB) && cnt_nx <= CNT_W'(FRAME_BITS)) begin
        sdo_q <= resp_q[3'(cnt_nx - CNT_W'(DATA_LSB + 1))];
      end else begin
        sdo_q <= 1'b0;
      end
    end
  end

  // count and word survive the frame end so the core can pick them up
  always_ff @(posedge spi_sclk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
    end else begin
      shift_q <= {spi_sdi, shift_q[FRAME_BITS-1:1]};
      if (!in_frame_q) begin
        bit_cnt_q <= CNT_W'(1);
      end else if (bit_cnt_q <= CNT_W'(FRAME_BITS)) begin
        bit_cnt_q <= bit_cnt_q + CNT_W'(1);
      end
    end
  end

  assign spi_sdo = sdo_q;
  assign spi_sdo_oe = sdo_oe_q;

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic rpin_s1_q;
  logic rpin_s2_q;
  logic [NCH-1:0] txd_s1_q;
  logic [NCH-1:0] txd_s2_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      rpin_s1_q <= 1'b0;
      rpin_s2_q <= 1'b0;
      txd_s1_q <= '1;
      txd_s2_q <= '1;
    end else begin
      cs_s1_q <= spi_cs_b;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      rpin_s1_q <= reset_pin_level;
      rpin_s2_q <= rpin_s1_q;
      for (int i = 0; i < NCH; i++) begin
        txd_s1_q[i] <= txd_pin[i];
        txd_s2_q[i] <= txd_s1_q[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic frame_end;
  logic frame_ok;
  logic [6:0] cmd_addr;
  logic cmd_clear;
  logic clr_dev;
  logic clr_a;
  logic clr_b;

  assign frame_end = cs_s2_q && !cs_s3_q;
  assign frame_ok = bit_cnt_q == CNT_W'(FRAME_BITS);
  assign cmd_addr = shift_q[6:0];
  assign cmd_clear = shift_q[CMD_CLEAR_BIT];
  assign clr_dev = frame_end && frame_ok && cmd_clear && cmd_addr == ADDR_DEV_INFO;
  assign clr_a = frame_end && frame_ok && cmd_clear && cmd_addr == ADDR_BUS_A;
  assign clr_b = frame_end && frame_ok && cmd_clear && cmd_addr == ADDR_BUS_B;

  // ---------------------------------------------------------------
  // device information register
  // ---------------------------------------------------------------
  logic [1:0] prior_q;
  logic stuck_q;
  logic monerr_q;
  logic [1:0] wdcnt_q;
  logic invcmd_q;
  logic fo_q;
  logic [2:0] drv_hist_q;
  logic restart_fail;
  logic [1:0] wdcnt_nx;

  assign restart_fail = (restart_info.restart && (restart_info.watchdog_miss_count
    || restart_info.thermal_stage_two || restart_info.core_supply_low
    || (restart_info.core_supply_high && restart_info.core_overvoltage_reset_enable)))
    || restart_info.wake_failsafe;
  assign wdcnt_nx = (wdcnt_q == WD_TWO) ? WD_TWO : wdcnt_q + 2'h1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prior_q <= PRIOR_CLEARED;
    end else if (soft_reset) begin
      prior_q <= PRIOR_CLEARED;
    end else if (restart_fail) begin
      prior_q <= PRIOR_FAIL;
    end else if (restart_info.wake_sleep) begin
      prior_q <= PRIOR_SLEEP;
    end else if (clr_dev) begin
      prior_q <= PRIOR_CLEARED;
    end
  end

  // miss count is not host-clearable; a miss beats a good trigger
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdcnt_q <= WD_NONE;
      fo_q <= 1'b0;
    end else if (soft_reset) begin
      wdcnt_q <= WD_NONE;
      fo_q <= 1'b0;
    end else begin
      if (watchdog_miss) begin
        wdcnt_q <= wdcnt_nx;
      end else if (watchdog_ok) begin
        wdcnt_q <= WD_NONE;
      end
      if (watchdog_miss && (fail_cfg_one || wdcnt_nx == WD_TWO)) begin
        fo_q <= 1'b1;
      end else if (fail_output_release) begin
        fo_q <= 1'b0;
      end
    end
  end

  // pin lags its drive by the synchroniser, so compare with delayed drive
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drv_hist_q <= '0;
      stuck_q <= 1'b0;
      monerr_q <= 1'b0;
      invcmd_q <= 1'b0;
    end else if (soft_reset) begin
      drv_hist_q <= '0;
      stuck_q <= 1'b0;
      monerr_q <= 1'b0;
      invcmd_q <= 1'b0;
    end else begin
      drv_hist_q <= {drv_hist_q[1:0], reset_drive_low};
      if (&drv_hist_q && reset_drive_low && rpin_s2_q) begin
        stuck_q <= 1'b1;
      end else if (clr_dev) begin
        stuck_q <= 1'b0;
      end
      if (monitor_input_error) begin
        monerr_q <= 1'b1;
      end else if (clr_dev) begin
        monerr_q <= 1'b0;
      end
      if (frame_end && !frame_ok) begin
        invcmd_q <= 1'b1;
      end else if (clr_dev) begin
        invcmd_q <= 1'b0;
      end
    end
  end

  assign fail_output_pins = fo_q;

  // ---------------------------------------------------------------
  // transceiver fault codes and gating
  // ---------------------------------------------------------------
  function automatic logic [1:0] fault_code(input dbsr_trx_in_t t);
    if (t.tsd_evt) begin
      fault_code = FLT_TSD;
    end else if (t.txd_to_evt) begin
      fault_code = FLT_TXD;
    end else if (t.bus_to_evt) begin
      fault_code = FLT_BUS;
    end else begin
      fault_code = FLT_NONE;
    end
  endfunction

  logic [1:0] flt_q [NCH];
  logic canuv_q;
  logic can_uv_watch;
  logic [NCH-1:0] uv_now;
  logic [NCH-1:0] clr_ch;

  assign can_uv_watch = can_mode == CAN_NORMAL || can_mode == CAN_RX_ONLY
    || (can_mode == CAN_WAKE && can_wup_seen);
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      uv_now[i] = trx_in[i].supply_low;
      clr_ch[i] = clr_b;
    end
    uv_now[CH_CAN] = trx_in[CH_CAN].supply_low && can_uv_watch;
    clr_ch[CH_CAN] = clr_a;
    clr_ch[1] = clr_a;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      canuv_q <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        flt_q[i] <= FLT_NONE;
      end
    end else if (soft_reset) begin
      canuv_q <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        flt_q[i] <= FLT_NONE;
      end
    end else begin
      if (uv_now[CH_CAN]) begin
        canuv_q <= 1'b1;
      end else if (clr_a) begin
        canuv_q <= 1'b0;
      end
      for (int i = 0; i < NCH; i++) begin
        if (fault_code(trx_in[i]) != FLT_NONE) begin
          flt_q[i] <= fault_code(trx_in[i]);
        end else if (clr_ch[i]) begin
          flt_q[i] <= FLT_NONE;
        end
      end
    end
  end

  dbsr_tx_state_t tx_st_q [NCH];
  logic [ARM_W-1:0] arm_cnt_q [NCH];
  logic [NCH-1:0] blk_txd_q;
  logic [NCH-1:0] blk_bus_q;
  logic [NCH-1:0] blk_tsd_q;
  logic [NCH-1:0] tx_en_q;
  logic [NCH-1:0] blocked;

  // cause latches: each held until its own recovery condition
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blk_txd_q <= '0;
      blk_bus_q <= '0;
      blk_tsd_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (trx_in[i].txd_to_evt) begin
          blk_txd_q[i] <= 1'b1;
        end else if (txd_s2_q[i] || trx_in[i].quiet) begin
          blk_txd_q[i] <= 1'b0;
        end
        if (trx_in[i].bus_to_evt) begin
          blk_bus_q[i] <= 1'b1;
        end else if (!trx_in[i].bus_dom || trx_in[i].quiet) begin
          blk_bus_q[i] <= 1'b0;
        end
        if (trx_in[i].tsd_evt) begin
          blk_tsd_q[i] <= 1'b1;
        end else if (!trx_in[i].hot) begin
          blk_tsd_q[i] <= 1'b0;
        end
      end
    end
  end

  // undervoltage is a live level, so it lifts once the supply is back
  assign blocked = blk_txd_q | blk_bus_q | blk_tsd_q | uv_now;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_en_q <= '1;
      for (int i = 0; i < NCH; i++) begin
        tx_st_q[i] <= TX_ON;
        arm_cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        unique case (tx_st_q[i])
          TX_ON: begin
            if (blocked[i]) begin
              tx_st_q[i] <= TX_HOLD;
              tx_en_q[i] <= 1'b0;
            end
          end
          TX_HOLD: begin
            arm_cnt_q[i] <= '0;
            if (!blocked[i]) begin
              tx_st_q[i] <= TX_ARM;
            end
          end
          TX_ARM: begin
            if (blocked[i]) begin
              tx_st_q[i] <= TX_HOLD;
            end else if (!txd_s2_q[i]) begin
              arm_cnt_q[i] <= '0;
            end else if (arm_cnt_q[i] == ARM_W'(TX_EN_CYC - 1)) begin
              tx_st_q[i] <= TX_ON;
              tx_en_q[i] <= 1'b1;
            end else begin
              arm_cnt_q[i] <= arm_cnt_q[i] + ARM_W'(1);
            end
          end
          default: begin
            tx_st_q[i] <= TX_HOLD;
            tx_en_q[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  assign tx_enable = tx_en_q;

  // ---------------------------------------------------------------
  // read-back
  // ---------------------------------------------------------------
  logic [7:0] rd_dev;
  logic [7:0] rd_a;
  logic [7:0] rd_b;

  assign rd_dev = {prior_q, stuck_q, monerr_q, wdcnt_q, invcmd_q, fo_q};
  assign rd_a = {1'b0, flt_q[1], 2'b00, flt_q[CH_CAN], canuv_q};
  assign rd_b = {1'b0, flt_q[4], flt_q[3], flt_q[2], 1'b0};

  // answer goes out in the next frame; reads show the value before any clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_q <= REG_RST;
    end else if (frame_end) begin
      if (!frame_ok) begin
        resp_q <= REG_RST;
      end else if (cmd_addr == ADDR_DEV_INFO) begin
        resp_q <= rd_dev;
      end else if (cmd_addr == ADDR_BUS_A) begin
        resp_q <= rd_a;
      end else if (cmd_addr == ADDR_BUS_B) begin
        resp_q <= rd_b;
      end else begin
        resp_q <= REG_RST;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  prior_fail_a: assert property (restart_fail && !soft_reset |=> prior_q == PRIOR_FAIL)
    else $error("failure restart did not record code 01");
  wd_clear_a: assert property (watchdog_ok && !watchdog_miss && !soft_reset
    |=> wdcnt_q == WD_NONE)
    else $error("good trigger did not clear miss count");
  wd_range_a: assert property (wdcnt_q != 2'h3)
    else $error("miss count reached 11");
  inv_set_a: assert property (frame_end && !frame_ok && !soft_reset |=> invcmd_q)
    else $error("malformed frame not flagged");
  inv_hold_a: assert property (invcmd_q && !clr_dev && !soft_reset |=> invcmd_q)
    else $error("invalid command flag dropped without clear");
  fo_read_a: assert property (frame_end && frame_ok && cmd_addr == ADDR_DEV_INFO
    |=> resp_q[DI_FOACT] == $past(fo_q))
    else $error("fail output bit does not follow outputs");
  canuv_off_a: assert property (uv_now[CH_CAN] && tx_st_q[CH_CAN] == TX_ON
    |=> !tx_enable[CH_CAN] && canuv_q)
    else $error("CAN undervoltage left transmitter on");
  arm_time_a: assert property ($rose(tx_enable[CH_CAN])
    |-> $past(arm_cnt_q[CH_CAN]) == ARM_W'(TX_EN_CYC - 1) && $past(txd_s2_q[CH_CAN]))
    else $error("transmitter enabled before enable time");
  set_wins_a: assert property (fault_code(trx_in[1]) != FLT_NONE && clr_a && !soft_reset
    |=> flt_q[1] != FLT_NONE)
    else $error("clear swallowed a coincident fault");
  resv_zero_a: assert property (frame_end && frame_ok && cmd_addr == ADDR_BUS_B
    |=> resp_q[7] == 1'b0 && resp_q[0] == 1'b0)
    else $error("reserved bit read as one");

  restart_c: cover property (restart_fail ##1 clr_dev);
  rearm_c: cover property (tx_st_q[CH_CAN] == TX_ARM ##[1:200] tx_enable[CH_CAN]);
  clear_c: cover property (clr_a ##1 flt_q[1] == FLT_NONE);
endmodule

// >>> testbench/dbsr_host_model.sv
// host serial master model driving 16-bit command frames
module dbsr_host_model (
  // serial pins
  output logic spi_sclk,
  output logic spi_cs_b,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_b = 1'b1;
    spi_sdi = 1'b0;
  end
  // sclk stands still between frames; trailing wait keeps the idle gap
  task automatic xfer(input logic [6:0] addr, input logic clr, input logic [7:0] pad,
    input int nbits, output logic [7:0] resp);
    logic [15:0] word;
    word = {pad, clr, addr};
    resp = 8'h00;
    spi_cs_b = 1'b0;
    #20;
    for (int k = 0; k < nbits; k++) begin
      spi_sdi = word[k];
      #3 spi_sclk = 1'b1;
      #3 spi_sclk = 1'b0;
      // undriven sdo is read inverted so a missing enable shows
      if (k > 7 && k < 16) resp[k-8] = spi_sdo_oe ? spi_sdo : ~spi_sdo;
    end
    #20 spi_cs_b = 1'b1;
    spi_sdi = ~spi_sdi;
    #150;
  endtask
endmodule

// >>> testbench/device_bus_status_regs_tb.sv
// self-checking bench of the status register bank
module device_bus_status_regs_tb
  import dbsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_b, soft_reset, spi_sclk, spi_cs_b, spi_sdi, spi_sdo, spi_sdo_oe;
  dbsr_restart_t restart_info;
  logic watchdog_miss, watchdog_ok, fail_cfg_one, fail_output_release;
  logic monitor_input_error, reset_drive_low, reset_pin_level, fail_output_pins;
  dbsr_trx_in_t trx_in [NCH];
  logic txd_pin [NCH];
  dbsr_can_mode_t can_mode;
  logic can_wup_seen, en;
  logic [NCH-1:0] tx_enable;
  logic [31:0] lfsr;
  logic [7:0] got;
  logic [2:0] m;
  int n_mismatch, tests_run, cyc, ch;
  logic [7:0] rs_tab [8] = '{8'hC0, 8'hA0, 8'h90, 8'h8C, 8'h82, 8'h81, 8'h88, 8'h83};
  logic [1:0] pr_tab [8] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1};
  dbsr_status_regs uut (.clk, .rst_b, .soft_reset, .spi_sclk, .spi_cs_b, .spi_sdi,
    .spi_sdo, .spi_sdo_oe, .restart_info, .watchdog_miss, .watchdog_ok, .fail_cfg_one,
    .fail_output_release, .monitor_input_error, .reset_drive_low, .reset_pin_level,
    .fail_output_pins, .trx_in, .txd_pin, .can_mode, .can_wup_seen, .tx_enable);
  dbsr_host_model host (.spi_sclk, .spi_cs_b, .spi_sdi, .spi_sdo, .spi_sdo_oe);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // f: stuck pin, monitor error, invalid command, fail outputs
  function automatic logic [7:0] di_byte(logic [1:0] pr, logic [1:0] wd, logic [3:0] f);
    return {pr, f[3], f[2], wd, f[1], f[0]};
  endfunction
  function automatic logic [7:0] flt_byte(int c, logic [1:0] code);
    int p;
    p = (c == CH_CAN) ? BA_CAN_LSB : (c == 1) ? BA_LIN1_LSB : 2 * c - 3;
    return 8'({6'h00, code} << p);
  endfunction
  function automatic logic [6:0] flt_addr(int c);
    return (c < 2) ? ADDR_BUS_A : ADDR_BUS_B;
  endfunction
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask
  // answer comes one frame late, so a read takes two frames
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    logic [7:0] d;
    lfsr = lfsr_next(lfsr);
    host.xfer(a, 1'b0, lfsr[7:0], 16, d);
    host.xfer(a, 1'b0, lfsr[15:8], 16, v);
    tick(1);
  endtask
  task automatic clr(input logic [6:0] a);
    logic [7:0] d;
    host.xfer(a, 1'b1, 8'h00, 16, d);
    tick(1);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic zero_check(input string s);
    for (int a = 0; a < 3; a++) begin
      rd(ADDR_DEV_INFO + 7'(a), got);
      chk_byte(got, REG_RST);
    end
    done(s);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {rst_b, soft_reset, watchdog_miss, watchdog_ok, fail_cfg_one} = 5'h00;
    {fail_output_release, monitor_input_error, reset_drive_low} = 3'h0;
    {reset_pin_level, can_wup_seen} = 2'h0;
    restart_info = '0;
    can_mode = CAN_OFF;
    lfsr = 32'h5B99D1F5;
    for (int i = 0; i < NCH; i++) begin
      trx_in[i] = '0;
      txd_pin[i] = 1'b1;
    end
    tick(2);
    rst_b = 1'b1;
    tick(4);
    chk_byte({3'h0, tx_enable}, 8'h1F);
    zero_check("reset");
    pulse(monitor_input_error);
    {reset_drive_low, reset_pin_level} = 2'h3;
    tick(8);
    {reset_drive_low, reset_pin_level} = 2'h0;
    fail_cfg_one = 1'b1;
    pulse(watchdog_miss);
    chk_bit(fail_output_pins, 1'b1);
    rd(ADDR_DEV_INFO, got);
    chk_byte(got, di_byte(PRIOR_CLEARED, WD_ONE, 4'hD));
    pulse(watchdog_miss);
    pulse(watchdog_miss);
    clr(ADDR_DEV_INFO);
    rd(ADDR_DEV_INFO, got);
    chk_byte(got, di_byte(PRIOR_CLEARED, WD_TWO, 4'h1));
    pulse(watchdog_ok);
    pulse(fail_output_release);
    fail_cfg_one = 1'b0;
    pulse(watchdog_miss);
    chk_bit(fail_output_pins, 1'b0);
    pulse(watchdog_miss);
    chk_bit(fail_output_pins, 1'b1);
    pulse(watchdog_ok);
    pulse(fail_output_release);
    rd(ADDR_DEV_INFO, got);
    chk_byte(got, REG_RST);
    done("device info");
    trx_in[CH_CAN].bus_to_evt = 1'b1;
    tick(1);
    trx_in[CH_CAN].bus_to_evt = 1'b0;
    host.xfer(ADDR_BUS_A, 1'b1, 8'h00, 15, got);
    rd(ADDR_BUS_A, got);
    chk_byte(got, flt_byte(CH_CAN, FLT_BUS));
    tick(40);
    rd(ADDR_DEV_INFO, got);
    chk_byte(got, di_byte(PRIOR_CLEARED, WD_NONE, 4'h2));
    clr(ADDR_DEV_INFO);
    clr(ADDR_BUS_A);
    rd(ADDR_DEV_INFO, got);
    chk_byte(got, REG_RST);
    done("invalid frame");
    for (int i = 0; i < 8; i++) begin
      restart_info = dbsr_restart_t'(rs_tab[i]);
      tick(1);
      restart_info = '0;
      rd(ADDR_DEV_INFO, got);
      chk_byte(got, di_byte(pr_tab[i], WD_NONE, 4'h0));
      clr(ADDR_DEV_INFO);
    end
    done("restart");
    // first 15 passes walk every channel and code, the rest mix events at random
    for (int i = 0; i < 27; i++) begin
      lfsr = lfsr_next(lfsr);
      ch = (i < 15) ? i / 3 : int'(lfsr[10:8]) % NCH;
      m = (i < 15) ? 3'(4 >> (i % 3)) : ((lfsr[2:0] == 3'h0) ? 3'h1 : lfsr[2:0]);
      trx_in[ch] = dbsr_trx_in_t'({m, 4'h0});
      tick(1);
      trx_in[ch] = '0;
      rd(flt_addr(ch), got);
      chk_byte(got, flt_byte(ch, m[2] ? FLT_TSD : m[1] ? FLT_TXD : FLT_BUS));
      clr(flt_addr(ch));
    end
    trx_in[1].bus_to_evt = 1'b1;
    clr(ADDR_BUS_A);
    trx_in[1].bus_to_evt = 1'b0;
    rd(ADDR_BUS_A, got);
    chk_byte(got, flt_byte(1, FLT_BUS));
    clr(ADDR_BUS_A);
    done("fault codes");
    for (int i = 0; i < 8; i++) begin
      tick(TX_EN_CYC + 4);
      chk_bit(tx_enable[CH_CAN], 1'b1);
      can_mode = dbsr_can_mode_t'(i / 2);
      can_wup_seen = i[0];
      en = (can_mode == CAN_NORMAL) || (can_mode == CAN_RX_ONLY)
        || (can_mode == CAN_WAKE && can_wup_seen);
      trx_in[CH_CAN].supply_low = 1'b1;
      tick(3);
      chk_bit(tx_enable[CH_CAN], !en);
      trx_in[CH_CAN].supply_low = 1'b0;
      rd(ADDR_BUS_A, got);
      chk_byte(got, {7'h00, en});
      clr(ADDR_BUS_A);
    end
    done("can undervoltage");
    trx_in[2] = dbsr_trx_in_t'(7'h14);
    txd_pin[3] = 1'b0;
    trx_in[3].txd_to_evt = 1'b1;
    tick(1);
    trx_in[2].bus_to_evt = 1'b0;
    trx_in[3].txd_to_evt = 1'b0;
    tick(TX_EN_CYC + 20);
    chk_bit(tx_enable[2], 1'b0);
    chk_bit(tx_enable[3], 1'b0);
    trx_in[2].bus_dom = 1'b0;
    txd_pin[3] = 1'b1;
    tick(TX_EN_CYC / 2);
    txd_pin[2] = 1'b0;
    tick(4);
    txd_pin[2] = 1'b1;
    tick(TX_EN_CYC - 10);
    chk_bit(tx_enable[2], 1'b0);
    chk_bit(tx_enable[3], 1'b1);
    tick(20);
    chk_bit(tx_enable[2], 1'b1);
    trx_in[4] = dbsr_trx_in_t'(7'h15);
    tick(1);
    trx_in[4].bus_to_evt = 1'b0;
    tick(2);
    chk_bit(tx_enable[4], 1'b0);
    tick(TX_EN_CYC + 10);
    chk_bit(tx_enable[4], 1'b1);
    done("recovery");
    pulse(monitor_input_error);
    pulse(soft_reset);
    zero_check("soft reset");
    results();
  end
endmodule
